// ===== rtl/flash_sector_select_and_status.sv
// Contract
// - identity register: size code bits 3:0 (0 none, 2 = 256 Kbit), type bits 5:4.
// - primary flash is eight 64 Kbyte sectors, each with own select.
// - secondary flash is four 8 Kbyte sectors, each with own select.
// - each sector has protection blocking program and erase.
// - sector erase can be suspended for reads, then resumed.
// - all memory selects come from user-programmed decode equations.
// - each sector select ORs up to three product terms.
// - optional half select, up to three terms, replaces bus address bit.
// - half select low picks lower 32KB, high picks upper 32KB.
// - without half equation, bus address bit 15 goes straight through.
// - half select does not change sector erase extent.
// - half select applies to all eight primary sectors together.
// - ready/busy drives 0 while any program or erase runs.
// - ready/busy drives 1 when no program or erase runs.
// - page register resets to all zeros.
//
// Design decisions made here: the register addresses and the APB register port.
module flash_sector_select_and_status
  import flash_select_pkg::*;
#(
  parameter logic [3:0] secondary_size = size_256kbit,
  parameter logic [1:0] secondary_type = type_flash,
  parameter int busy_cycles = busy_cycles_default
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [addr_width-1:0] bus_addr,
  output logic [primary_sectors-1:0] primary_sector_select,
  output logic [secondary_sectors-1:0] secondary_sector_select,
  output logic sram_block_select,
  output logic primary_half_select,
  output logic erase_whole_sector,
  output logic ready_busy_pin,
  output logic irq
);

  localparam int num_sel = primary_sectors + secondary_sectors + 1;
  localparam int num_terms = (num_sel + 1) * product_terms;
  localparam logic [11:0] term_last = 12'(int'(reg_term_base) + 4 * (num_terms * 3 - 1));
  localparam logic [15:0] busy_count = 16'(busy_cycles);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] page_value;
    logic [primary_sectors-1:0] primary_protect;
    logic [secondary_sectors-1:0] secondary_protect;
    logic half_enable;
    term_s [num_terms-1:0] terms;
    op_state_e op;
    logic op_erase;
    logic op_secondary;
    logic [2:0] op_sector;
    logic [15:0] count;
    logic [irq_bits-1:0] irq_status;
    logic [irq_bits-1:0] irq_mask;
    logic [primary_sectors-1:0] primary_select;
    logic [secondary_sectors-1:0] secondary_select;
    logic sram_select;
    logic half_select;
    logic erase_whole;
    logic ready;
    logic irq;
  } state_s;

  state_s r;
  state_s next_r;

  // product term inputs: low four page bits XORed into the top four bus address bits
  function automatic logic term_hit(term_s t, logic [addr_width-1:0] a);
    return t.enable && (((a ^ t.value) & t.care) == '0);
  endfunction

  function automatic logic select_of(state_s s, int idx, logic [addr_width-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < product_terms; k++) begin
      hit = hit | term_hit(s.terms[idx * product_terms + k], a);
    end
    return hit;
  endfunction

  logic setup;
  logic access;
  logic [31:0] rd;
  logic [7:0] word_ix;
  logic [addr_width-1:0] dec_in;

  always_comb begin
    next_r = r;
    setup = psel && !penable;
    access = psel && penable;
    word_ix = 8'((paddr - reg_term_base) >> 2);
    // low four page bits are XORed into the top four address bits seen by the decoder
    dec_in = {r.page_value[3:0] ^ bus_addr[addr_width-1:addr_width-4], bus_addr[addr_width-5:0]};
    rd = '0;
    unique case (paddr)
      reg_identity: rd = {26'h0, secondary_type, secondary_size};
      reg_page: rd = {24'h0, r.page_value};
      reg_primary_protect: rd = {24'h0, r.primary_protect};
      reg_secondary_protect: rd = {28'h0, r.secondary_protect};
      reg_half_ctrl: rd = {31'h0, r.half_enable};
      reg_op_ctrl: rd = {24'h0, 1'b0, 1'b0, r.op_sector, r.op_secondary, r.op_erase, 1'b0};
      reg_status: rd = {28'h0, r.op == op_suspended, r.op == op_busy, r.ready, 1'b0};
      reg_irq_status: rd = {30'h0, r.irq_status};
      reg_irq_mask: rd = {30'h0, r.irq_mask};
      default: begin
        if (paddr >= reg_term_base && paddr <= term_last && paddr[1:0] == 2'b00) begin
          unique case (word_ix % 3)
            0: rd = {31'h0, r.terms[word_ix / 3].enable};
            1: rd = 32'(r.terms[word_ix / 3].care);
            default: rd = 32'(r.terms[word_ix / 3].value);
          endcase
        end
      end
    endcase

    // apb: one wait-free access phase
    next_r.pready = setup;
    next_r.pslverr = 1'b0;
    if (setup) begin
      next_r.prdata = pwrite ? 32'h0 : rd;
      next_r.pslverr = !(paddr inside {reg_identity, reg_page, reg_primary_protect, reg_secondary_protect,
        reg_half_ctrl, reg_op_ctrl, reg_status, reg_irq_status, reg_irq_mask})
        && !(paddr >= reg_term_base && paddr <= term_last && paddr[1:0] == 2'b00);
    end

    // operation engine
    if (r.op == op_busy) begin
      if (r.count != '0) begin
        next_r.count = r.count - 16'h1;
      end else begin
        next_r.op = op_idle;
        next_r.irq_status[irq_done] = 1'b1;
      end
    end

    // the access edge is the one at which pready stands high
    if (access && r.pready && !pwrite && paddr == reg_irq_status) begin
      next_r.irq_status = '0;
      if (r.op == op_busy && r.count == '0) begin
        next_r.irq_status[irq_done] = 1'b1;
      end
    end

    if (access && r.pready && pwrite && !r.pslverr) begin
      unique case (paddr)
        reg_page: next_r.page_value = pwdata[7:0];
        reg_primary_protect: next_r.primary_protect = pwdata[primary_sectors-1:0];
        reg_secondary_protect: next_r.secondary_protect = pwdata[secondary_sectors-1:0];
        reg_half_ctrl: next_r.half_enable = pwdata[0];
        reg_irq_mask: next_r.irq_mask = pwdata[irq_bits-1:0];
        reg_op_ctrl: begin
          if (pwdata[op_start] && r.op == op_idle) begin
            next_r.op_erase = pwdata[op_erase];
            next_r.op_secondary = pwdata[op_secondary];
            next_r.op_sector = pwdata[op_sector_lo +: 3];
            if ((pwdata[op_secondary] ? r.secondary_protect[pwdata[op_sector_lo +: 2]]
                                      : r.primary_protect[pwdata[op_sector_lo +: 3]])) begin
              next_r.irq_status[irq_violation] = 1'b1;
            end else begin
              next_r.op = op_busy;
              next_r.count = busy_count;
            end
          end else if (pwdata[op_suspend] && r.op == op_busy && r.op_erase) begin
            next_r.op = op_suspended;
          end else if (pwdata[op_resume] && r.op == op_suspended) begin
            next_r.op = op_busy;
          end
        end
        default: begin
          if (paddr >= reg_term_base && paddr <= term_last && paddr[1:0] == 2'b00) begin
            unique case (word_ix % 3)
              0: next_r.terms[word_ix / 3].enable = pwdata[0];
              1: next_r.terms[word_ix / 3].care = pwdata[addr_width-1:0];
              default: next_r.terms[word_ix / 3].value = pwdata[addr_width-1:0];
            endcase
          end
        end
      endcase
    end

    // decode outputs
    for (int i = 0; i < primary_sectors; i++) begin
      next_r.primary_select[i] = select_of(r, i, dec_in);
    end
    for (int i = 0; i < secondary_sectors; i++) begin
      next_r.secondary_select[i] = select_of(r, primary_sectors + i, dec_in);
    end
    next_r.sram_select = select_of(r, num_sel - 1, dec_in);
    // shared half select for all primary sectors
    next_r.half_select = r.half_enable ? select_of(r, num_sel, dec_in)
                                       : bus_addr[primary_half_bit];
    next_r.erase_whole = (next_r.op == op_busy) && next_r.op_erase;
    // a suspended erase is not erasing, so the pin shows ready
    next_r.ready = (next_r.op != op_busy);
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.page_value <= page_reset;
      r.op <= op_idle;
      r.ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign primary_sector_select = r.primary_select;
  assign secondary_sector_select = r.secondary_select;
  assign sram_block_select = r.sram_select;
  assign primary_half_select = r.half_select;
  assign erase_whole_sector = r.erase_whole;
  assign ready_busy_pin = r.ready;
  assign irq = r.irq;

endmodule // flash_sector_select_and_status

// ===== rtl/flash_select_pkg.sv
package flash_select_pkg;

  localparam int primary_sectors = 8;
  localparam int secondary_sectors = 4;
  localparam int product_terms = 3;
  localparam int addr_width = 20;
  localparam int primary_half_bit = 15;

  // register byte offsets; twelve bits so that all product term words are reachable
  localparam logic [11:0] reg_identity = 12'h000;
  localparam logic [11:0] reg_page = 12'h004;
  localparam logic [11:0] reg_primary_protect = 12'h008;
  localparam logic [11:0] reg_secondary_protect = 12'h00C;
  localparam logic [11:0] reg_half_ctrl = 12'h010;
  localparam logic [11:0] reg_op_ctrl = 12'h014;
  localparam logic [11:0] reg_status = 12'h018;
  localparam logic [11:0] reg_irq_status = 12'h01C;
  localparam logic [11:0] reg_irq_mask = 12'h020;
  localparam logic [11:0] reg_term_base = 12'h040;

  // identity fields
  localparam logic [3:0] size_none = 4'h0;
  localparam logic [3:0] size_256kbit = 4'h2;
  localparam logic [1:0] type_flash = 2'h0;
  localparam logic [7:0] page_reset = 8'h00;

  // op_ctrl layout: [0] start, [1] erase (else program), [2] secondary block,
  // [5:3] sector, [6] suspend, [7] resume
  localparam int op_start = 0;
  localparam int op_erase = 1;
  localparam int op_secondary = 2;
  localparam int op_sector_lo = 3;
  localparam int op_suspend = 6;
  localparam int op_resume = 7;

  // irq bits: [0] done, [1] protect violation
  localparam int irq_bits = 2;
  localparam int irq_done = 0;
  localparam int irq_violation = 1;

  localparam int busy_cycles_default = 16;

  // one product term: match where care bits agree with value bits
  typedef struct packed {
    logic enable;
    logic [addr_width-1:0] care;
    logic [addr_width-1:0] value;
  } term_s;

  typedef enum logic [1:0] {op_idle, op_busy, op_suspended} op_state_e;

endpackage : flash_select_pkg

// ===== tb/flash_select_chk.sv
module flash_select_chk
  import flash_select_pkg::*;
#(
  parameter logic [3:0] secondary_size = size_256kbit,
  parameter logic [1:0] secondary_type = type_flash,
  parameter int busy_cycles = busy_cycles_default
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic erase_whole_sector,
  input wire logic ready_busy_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  answer_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  refused_zero_a: assert property (pslverr |-> pready && prdata == 32'h00000000) else $error("bad refusal");
  identity_value_a: assert property (pready && !pwrite && paddr == reg_identity |->
    prdata == {24'h000000, 2'b00, secondary_type, secondary_size}) else $error("identity value wrong");
  erase_busy_a: assert property (erase_whole_sector |-> !ready_busy_pin) else $error("ready during erase");
  busy_hold_a: assert property ($fell(ready_busy_pin) |-> !ready_busy_pin [*3]) else $error("busy too short");
  busy_ends_a: assert property ($fell(ready_busy_pin) |-> ##[1:600] ready_busy_pin) else $error("never ready");
endmodule // flash_select_chk

bind flash_sector_select_and_status flash_select_chk #(.secondary_size(secondary_size),
  .secondary_type(secondary_type), .busy_cycles(busy_cycles)) i_chk (.*);

// ===== tb/mcu_bus_model.sv
module mcu_bus_model (
  input wire logic pclk,
  input wire logic [19:0] want,
  output logic [19:0] bus_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // the microcontroller always drives its address bus, changing it just after a clock edge
  initial bus_addr = 20'h00000;
  always @(posedge pclk) bus_addr <= want;
endmodule // mcu_bus_model

// ===== tb/test_flash_sector_select_and_status.sv
module test_flash_sector_select_and_status;
  import flash_select_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int busy = 6;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [7:0] primary_sector_select;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, sram_block_select, primary_half_select, erase_whole_sector, ready_busy_pin, irq;
  logic [3:0] secondary_sector_select;
  logic [addr_width-1:0] want = '0, bus_addr;
  int num_errors = 0, n_compared = 0, n;
  always #20 pclk = ~pclk;
  mcu_bus_model i_mcu (.pclk(pclk), .want(want), .bus_addr(bus_addr));
  flash_sector_select_and_status #(.busy_cycles(busy)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_addr(bus_addr), .primary_sector_select(primary_sector_select),
    .secondary_sector_select(secondary_sector_select), .sram_block_select(sram_block_select),
    .primary_half_select(primary_half_select), .erase_whole_sector(erase_whole_sector),
    .ready_busy_pin(ready_busy_pin), .irq(irq));
  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) begin
        num_errors++;
        report_and_stop();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_rdy(input logic v);
    n = 0;
    while (ready_busy_pin !== v) begin
      @(posedge pclk);
      n++;
      if (n > 300) begin
        num_errors++;
        report_and_stop();
      end
    end
  endtask
  // t is the product term slot: select s owns slots 3s to 3s+2
  task automatic term(input int t, input logic [31:0] care, input logic [31:0] val);
    apb(1, 12'(reg_term_base + 12 * t), 32'h1);
    apb(1, 12'(reg_term_base + 12 * t + 4), care);
    apb(1, 12'(reg_term_base + 12 * t + 8), val);
  endtask
  task automatic go(input logic [19:0] a);
    want <= a;
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset();
    chk(ready_busy_pin, 1);
    apb(0, reg_identity, 0);
    chk(rd, {26'h0, type_flash, size_256kbit});
    apb(1, reg_identity, 32'hFF);
    apb(0, reg_identity, 0);
    chk(rd[7:6], 0);
    apb(0, reg_page, 0);
    chk(rd, 0);
    apb(0, 12'h024, 0);
    chk(err, 1);
  endtask
  task automatic t_decode();
    logic [19:0] adr [4] = '{20'h12345, 20'h30000, 20'h50000, 20'h60000};
    logic [12:0] exp [4] = '{13'h020, 13'h020, 13'h002, 13'h001};
    term(0, 32'hF0000, 32'h10000);
    term(1, 32'hF0000, 32'h30000);
    term(24, 32'hF0000, 32'h50000);
    term(36, 32'hF0000, 32'h60000);
    foreach (adr[i]) begin
      go(adr[i]);
      chk({primary_sector_select, secondary_sector_select, sram_block_select}, exp[i]);
    end
  endtask
  task automatic t_half();
    go(20'h08000);
    chk(primary_half_select, 1);
    apb(1, reg_half_ctrl, 1);
    term(39, 32'h10000, 32'h10000);
    go(20'h08000);
    chk(primary_half_select, 0);
    apb(1, reg_page, 1);
    go(20'h08000);
    chk(primary_half_select, 1);
    apb(1, reg_page, 0);
  endtask
  task automatic t_erase();
    apb(1, reg_irq_mask, 1);
    apb(1, reg_op_ctrl, 32'h13);
    wait_rdy(0);
    chk(erase_whole_sector, 1);
    wait_rdy(1);
    chk(n, busy + 1);
    @(posedge pclk);
    chk(irq, 1);
    apb(0, reg_irq_status, 0);
    chk(rd, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
  endtask
  task automatic t_protect();
    apb(1, reg_primary_protect, 32'h08);
    apb(1, reg_op_ctrl, 32'h1B);
    repeat (3) @(posedge pclk);
    chk(ready_busy_pin, 1);
    chk(irq, 0);
    apb(0, reg_irq_status, 0);
    chk(rd, 2);
  endtask
  task automatic t_suspend();
    apb(1, reg_op_ctrl, 32'h13);
    wait_rdy(0);
    apb(1, reg_op_ctrl, 32'h40);
    wait_rdy(1);
    repeat (2 * busy) @(posedge pclk);
    chk({ready_busy_pin, erase_whole_sector}, 2'b10);
    apb(1, reg_op_ctrl, 32'h80);
    wait_rdy(0);
    wait_rdy(1);
    apb(0, reg_irq_status, 0);
    chk(rd, 1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_decode();
    t_half();
    t_erase();
    t_protect();
    t_suspend();
    report_and_stop();
  end
endmodule // test_flash_sector_select_and_status
